// ---- tb_timer_shared_io_port.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_timer_shared_io_port;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  tmr_oc_en = 8'h0, tmr_ic_sel = 8'h0, tmr_oc_lvl = 8'h0;
   logic [7:0]  ext_lvl = 8'h0, tmr_pin_lvl, pin_out, pin_oe, pin_in;
   int          mismatches = 0, cmp_count = 0;
   localparam logic [19:0] a_dir = tpio_pkg::DIR_ADDR;
   localparam logic [19:0] a_dat = tpio_pkg::DATA_ADDR;
   localparam logic [1:0]  ok = tpio_pkg::RESP_OKAY;

   tpio_port      tpio_port_inst (.*);
   tpio_pin_model tpio_pin_model_inst (.*);
   always #20 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Ready is sampled mid-cycle, release follows at the taking edge
   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      logic ha, hw, hb;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid;
         if (hb) chk({s_axi_bresp, 32'h0}, {ok, 32'h0});
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
      end while (!hb);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      logic ha, hr;
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ha = s_axi_arvalid & s_axi_arready;
         hr = s_axi_rvalid;
         if (hr) chk({s_axi_rresp, s_axi_rdata}, {r, e});
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 1'b0;
      end while (!hr);
      s_axi_rready <= 1'b0;
   endtask
   // Undriven pads are don't care on pin_out
   task automatic pc(input logic [7:0] eo, input logic [7:0] ev);
      @(negedge aclk);
      chk({18'h0, pin_oe, pin_out & pin_oe}, {18'h0, eo, ev & eo});
      @(posedge aclk);
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(a_dir, 32'hff, ok);
      wr(a_dir, 8'hff);
      rd(a_dir, 32'hff, ok);
      rd(a_dat, 32'h00, ok);
      wr(a_dat, 8'ha5);
      ext_lvl <= 8'h5a;
      repeat (3) @(posedge aclk);
      rd(a_dat, 32'ha5, ok);
      pc(8'hff, 8'ha5);
      wr(a_dir, 8'h0f);
      ext_lvl <= 8'h3c;
      repeat (3) @(posedge aclk);
      rd(a_dat, 32'h35, ok);
      pc(8'h0f, 8'h05);
      tmr_oc_en <= 8'hf0; tmr_oc_lvl <= 8'hc0;
      rd(a_dat, 32'hc5, ok);
      pc(8'hff, 8'hc5);
      tmr_oc_en <= 8'h00; tmr_ic_sel <= 8'hff;
      repeat (4) @(posedge aclk);
      rd(a_dat, 32'h35, ok);
      chk({26'h0, tmr_pin_lvl}, 34'h35);
      tmr_oc_en <= 8'hf0; sw_standby <= 1'b1;
      repeat (2) @(posedge aclk);
      pc(8'h0f, 8'h05);
      rd(a_dat, 32'h35, ok);
      sw_standby <= 1'b0; tmr_oc_en <= 8'h00; hw_standby <= 1'b1;
      repeat (5) @(posedge aclk);
      hw_standby <= 1'b0;
      repeat (4) @(posedge aclk);
      pc(8'h00, 8'h00);
      wr(a_dir, 8'hff);
      rd(a_dat, 32'h00, ok);
      rd(20'h00010, 32'h0, tpio_pkg::RESP_SLVERR);
      report_and_stop;
   end
   // Whole sequence needs under a hundred cycles
   initial begin
      repeat (5000) @(posedge aclk);
      mismatches++;
      report_and_stop;
   end
endmodule
bind tpio_port tpio_port_chk tpio_port_chk_inst (.*);
`default_nettype wire

// ---- tpio_pin_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface tpio_pin_if;
   // Register side
   logic [7:0] dir;
   logic [7:0] data;
   // Timer side
   logic [7:0] oc_en;
   logic [7:0] ic_sel;
   logic [7:0] oc_lvl;
   // Synchronised pin level
   logic [7:0] pin_lvl;
   // Results
   logic [7:0] rd_val;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic [7:0] cap_lvl;

   modport regs (
      output dir, data, oc_en, ic_sel, oc_lvl, pin_lvl,
      input  rd_val, pin_out, pin_oe, cap_lvl
   );
   modport mux (
      input  dir, data, oc_en, ic_sel, oc_lvl, pin_lvl,
      output rd_val, pin_out, pin_oe, cap_lvl
   );
endinterface
`default_nettype wire

// ---- tpio_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_pin_model (
   // Pad side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_lvl,
   output logic [7:0]      pin_in
);
   // Undriven pads follow the outside source, driven pads the port
   assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// ---- tpio_pin_mux.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_pin_mux (
   // Per-pin function selection
   tpio_pin_if.mux p
);

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (p.oc_en[i]) begin
            // Compare output overrides direction and data
            p.pin_out[i] = p.oc_lvl[i];
            p.pin_oe[i]  = 1'b1;
            p.rd_val[i]  = p.oc_lvl[i];
            p.cap_lvl[i] = p.pin_lvl[i];
         end else if (p.dir[i]) begin
            p.pin_out[i] = p.data[i];
            p.pin_oe[i]  = 1'b1;
            p.rd_val[i]  = p.data[i];
            // Capture pin sees its own driven value
            p.cap_lvl[i] = p.ic_sel[i] ? p.data[i] : p.pin_lvl[i];
         end else begin
            p.pin_out[i] = p.data[i];
            p.pin_oe[i]  = 1'b0;
            p.rd_val[i]  = p.pin_lvl[i];
            p.cap_lvl[i] = p.pin_lvl[i];
         end
      end
   end

endmodule
`default_nettype wire

// ---- tpio_pkg.sv ----
`default_nettype none
package tpio_pkg;

   localparam int unsigned PORT_W   = 8;
   localparam int unsigned ADDR_W   = 20;
   localparam int unsigned DATA_W   = 32;

   // Printed offsets are register indices; byte address is four times that
   localparam logic [15:0] DIR_IDX  = 16'hfe85;
   localparam logic [15:0] DATA_IDX = 16'hfe87;
   localparam logic [19:0] DIR_ADDR  = {2'h0, DIR_IDX, 2'h0};
   localparam logic [19:0] DATA_ADDR = {2'h0, DATA_IDX, 2'h0};

   localparam logic [7:0]  DIR_RST  = 8'h00;
   localparam logic [7:0]  DATA_RST = 8'h00;
   localparam logic [7:0]  DIR_READ = 8'hff;

   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SEL_NONE,
      SEL_DIR,
      SEL_DATA
   } tpio_sel_t;

   // Word decode, low two address bits ignored
   function automatic tpio_sel_t reg_sel(input logic [19:0] addr);
      logic [19:0] a;
      a = {addr[19:2], 2'h0};
      if (a == DIR_ADDR) begin
         reg_sel = SEL_DIR;
      end else if (a == DATA_ADDR) begin
         reg_sel = SEL_DATA;
      end else begin
         reg_sel = SEL_NONE;
      end
   endfunction

endpackage
`default_nettype wire

// ---- tpio_port.sv ----
// Functional notes
// - Eight pins, each governed by one bit of the direction register.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only and reads as all ones.
// - Direction register clears on reset and hardware standby only.
// - Data register clears on reset and hardware standby only.
// - General output drives the stored bit; reads return the stored bit.
// - General input stores writes without driving; reads give the pin.
// - In every mode 1 to 7 each pin may be GPIO, capture or compare.
// - Compare output ignores direction and drives the timer level.
// - Compare pins ignore stored data and read back the timer level.
// - Capture pins keep their direction bit and act as GPIO too.
// - Capture output pin drives the stored bit and feeds it to timer.
// - Capture input pin reads the timer input level, not driven.
// - Software standby resets the timer so pins fall back to GPIO.
`timescale 1ns/10ps
`default_nettype none
module tpio_port (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [19:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [19:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Power state
   input  wire logic        hw_standby,
   input  wire logic        sw_standby,
   // Timer unit
   input  wire logic [7:0]  tmr_oc_en,
   input  wire logic [7:0]  tmr_ic_sel,
   input  wire logic [7:0]  tmr_oc_lvl,
   output logic [7:0]       tmr_pin_lvl,
   // Port pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe
);

   typedef enum logic [1:0] {
      WS_COLLECT,
      WS_RESP
   } tpio_wstate_t;

   tpio_pin_if pif ();

   logic [7:0]   dir_r;
   logic [7:0]   data_r;
   logic [7:0]   pin_s1_r;
   logic [7:0]   pin_s2_r;
   logic         hws_s1_r;
   logic         hws_s2_r;
   logic [7:0]   pin_out_r;
   logic [7:0]   pin_oe_r;
   logic [7:0]   cap_r;
   tpio_wstate_t wstate_r;
   logic         aw_got_r;
   logic         w_got_r;
   logic [19:0]  waddr_r;
   logic [7:0]   wdata_r;
   logic         wstrb0_r;
   logic [1:0]   bresp_r;
   logic         rvalid_r;
   logic [31:0]  rdata_r;
   logic [1:0]   rresp_r;
   logic         wr_go;

   ////////////////////////////////////////////////////////////////////////////
   // Pin and standby synchronisers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
         hws_s1_r <= 1'b0;
         hws_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
         hws_s1_r <= hw_standby;
         hws_s2_r <= hws_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Function selection

   // Timer is held in reset in software standby, so its claims drop
   assign pif.oc_en   = tmr_oc_en & ~{8{sw_standby}};
   assign pif.ic_sel  = tmr_ic_sel & ~{8{sw_standby}};
   assign pif.oc_lvl  = tmr_oc_lvl;
   assign pif.dir     = dir_r;
   assign pif.data    = data_r;
   assign pif.pin_lvl = pin_s2_r;

   // Same selection in every operating mode
   tpio_pin_mux u_mux (
      .p (pif.mux)
   );

   // Registered so pins never glitch on mux changes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_r <= 8'h00;
         pin_oe_r  <= 8'h00;
         cap_r     <= 8'h00;
      end else begin
         pin_out_r <= pif.pin_out;
         pin_oe_r  <= pif.pin_oe;
         cap_r     <= pif.cap_lvl;
      end
   end

   assign pin_out     = pin_out_r;
   assign pin_oe      = pin_oe_r;
   assign tmr_pin_lvl = cap_r;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel

   assign s_axi_awready = (wstate_r == WS_COLLECT) && !aw_got_r;
   assign s_axi_wready  = (wstate_r == WS_COLLECT) && !w_got_r;
   assign s_axi_bvalid  = (wstate_r == WS_RESP);
   assign s_axi_bresp   = bresp_r;
   assign wr_go         = (wstate_r == WS_COLLECT)
                          && (aw_got_r || s_axi_awvalid)
                          && (w_got_r || s_axi_wvalid);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstate_r <= WS_COLLECT;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         waddr_r  <= 20'h00000;
         wdata_r  <= 8'h00;
         wstrb0_r <= 1'b0;
         bresp_r  <= tpio_pkg::RESP_OKAY;
      end else begin
         case (wstate_r)
            WS_COLLECT: begin
               if (s_axi_awvalid && !aw_got_r) begin
                  aw_got_r <= 1'b1;
                  waddr_r  <= s_axi_awaddr;
               end
               if (s_axi_wvalid && !w_got_r) begin
                  w_got_r  <= 1'b1;
                  wdata_r  <= s_axi_wdata[7:0];
                  wstrb0_r <= s_axi_wstrb[0];
               end
               if (wr_go) begin
                  wstate_r <= WS_RESP;
                  aw_got_r <= 1'b0;
                  w_got_r  <= 1'b0;
                  bresp_r  <= (tpio_pkg::reg_sel(wa_eff()) ==
                               tpio_pkg::SEL_NONE) ?
                              tpio_pkg::RESP_SLVERR : tpio_pkg::RESP_OKAY;
               end
            end
            WS_RESP: begin
               if (s_axi_bready) begin
                  wstate_r <= WS_COLLECT;
               end
            end
            default: begin
               wstate_r <= WS_COLLECT;
            end
         endcase
      end
   end

   // Address and data of the write being committed this cycle
   function automatic logic [19:0] wa_eff();
      wa_eff = aw_got_r ? waddr_r : s_axi_awaddr;
   endfunction

   function automatic logic [7:0] wd_eff();
      wd_eff = w_got_r ? wdata_r : s_axi_wdata[7:0];
   endfunction

   function automatic logic ws_eff();
      ws_eff = w_got_r ? wstrb0_r : s_axi_wstrb[0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Port registers

   // Software standby is not a reset here: both registers hold
   always_ff @(posedge aclk) begin
      if (!aresetn || hws_s2_r) begin
         dir_r <= tpio_pkg::DIR_RST;
      end else if (wr_go && ws_eff()
                   && tpio_pkg::reg_sel(wa_eff()) == tpio_pkg::SEL_DIR) begin
         dir_r <= wd_eff();
      end
   end

   // Writes with strobe bit 0 set land, whether or not the pin is driven
   always_ff @(posedge aclk) begin
      if (!aresetn || hws_s2_r) begin
         data_r <= tpio_pkg::DATA_RST;
      end else if (wr_go && ws_eff()
                   && tpio_pkg::reg_sel(wa_eff()) == tpio_pkg::SEL_DATA) begin
         data_r <= wd_eff();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= tpio_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r  <= tpio_pkg::RESP_OKAY;
         case (tpio_pkg::reg_sel(s_axi_araddr))
            tpio_pkg::SEL_DIR: begin
               rdata_r <= {24'h000000, tpio_pkg::DIR_READ};
            end
            tpio_pkg::SEL_DATA: begin
               rdata_r <= {24'h000000, pif.rd_val};
            end
            default: begin
               rdata_r <= 32'h00000000;
               rresp_r <= tpio_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ---- tpio_port_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module tpio_port_chk (
   // Clock and bus
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [19:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   // Timer and pins
   input wire logic        sw_standby,
   input wire logic [7:0]  tmr_oc_en,
   input wire logic [7:0]  tmr_oc_lvl,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe
);
   logic [19:0] ra_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   // Address of the read in flight; low two bits cleared so any byte of a word decodes
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ra_r <= {s_axi_araddr[19:2], 2'h0};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   AST_RESET: assert property ($rose(aresetn) |-> pin_oe == 8'h00 &&
      !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not cleared");
   AST_OC_OE: assert property ($past(aresetn) && !$past(sw_standby) |->
      (pin_oe & $past(tmr_oc_en)) == $past(tmr_oc_en))
      else $error("compare pin not driven");
   AST_OC_LVL: assert property ($past(aresetn) && !$past(sw_standby) |->
      ((pin_out ^ $past(tmr_oc_lvl)) & $past(tmr_oc_en)) == 8'h00)
      else $error("compare level wrong");
   AST_DIR_RD: assert property (s_axi_rvalid &&
      ra_r == tpio_pkg::DIR_ADDR |-> s_axi_rdata == 32'h000000ff)
      else $error("direction read not all ones");
   AST_UPPER: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
   AST_SLVERR: assert property (s_axi_rvalid && ra_r != tpio_pkg::DIR_ADDR
      && ra_r != tpio_pkg::DATA_ADDR |-> s_axi_rresp == 2'h2 &&
      s_axi_rdata == 32'h00000000) else $error("unmapped read answered");
   AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid ##0 !s_axi_arready) else $error("read answer late");
   AST_WR_ANS: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write answer late");
   COV_OC: cover property (tmr_oc_en != 8'h00 ##1 pin_oe == 8'hff);
   COV_ERR: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   COV_SWSB: cover property (sw_standby && tmr_oc_en != 8'h00);
endmodule
`default_nettype wire
